// ### rtl/osc_defs.svh
// Register offsets, field positions, source codes and reset values.
`ifndef OSC_DEFS_SVH
`define OSC_DEFS_SVH
`define OSC_OFF_REQ 8'h00
`define OSC_OFF_CUR 8'h04
`define OSC_OFF_CTRL 8'h08
`define OSC_OFF_RDY 8'h0c
`define OSC_OFF_EN 8'h10
`define OSC_OFF_FRQ 8'h14
`define OSC_OFF_IST 8'h18
`define OSC_OFF_IMSK 8'h1c
`define OSC_BIT_HOLD 7
`define OSC_BIT_SPWR 6
`define OSC_BIT_CMPL 4
`define OSC_BIT_NRDY 3
`define OSC_SRC_MSB 6
`define OSC_SRC_LSB 4
`define OSC_DIV_MSB 3
`define OSC_DIV_LSB 0
`define OSC_FLG_MSB 7
`define OSC_FLG_LSB 2
`define OSC_BIT_MULTIPLIER_READY 0
`define OSC_FRQ_MSB 2
`define OSC_FRQ_LSB 0
`define OSC_IDX_EXT 5
`define OSC_IDX_HF 4
`define OSC_IDX_MF 3
`define OSC_IDX_LF 2
`define OSC_IDX_SOS 1
`define OSC_IDX_ADC 0
`define OSC_SRC_EXT 3'h7
`define OSC_SRC_HF 3'h6
`define OSC_SRC_LF 3'h5
`define OSC_SRC_SOS 3'h4
`define OSC_SRC_RSV1 3'h3
`define OSC_SRC_EXTPLL 3'h2
`define OSC_SRC_HFPLL 3'h1
`define OSC_SRC_RSV0 3'h0
`define OSC_FRQ_RSVD 3'h7
`define OSC_FRQ_4M 3'h2
`define OSC_FRQ_32M 3'h6
`define OSC_DIV_RST_HF 4'h2
`define OSC_DIV_RST 4'h0
`define OSC_SYNC_WAIT 2'h2
`define OSC_IRQ_HELD 0
`define OSC_IRQ_DONE 1
`endif

// ### rtl/osc_pkg.sv
// Types shared by the oscillator control block and its helpers.
package osc_pkg;
  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_WAIT, ST_HOLD} osc_sw_state_t;
  typedef struct packed {
    logic [1:0] event_set;
    logic [1:0] read_clr;
    logic mask_we;
    logic [1:0] mask_wd;
  } osc_irq_req_t;
  typedef struct packed {
    logic [1:0] status;
    logic [1:0] mask;
  } osc_irq_rsp_t;
  typedef struct packed {
    logic [5:0] osc_rdy;
    logic pll_lock;
    logic [5:0] mod_req;
    logic allow;
    logic [2:0] rst_src;
    logic [2:0] ext_mode;
  } osc_pins_t;
endpackage

// ### rtl/osc_sync.sv
// Two-stage synchroniser for a vector of slow level inputs.
`timescale 1ns/1ps
`default_nettype none
module osc_sync import osc_pkg::*; #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } osc_sync_st_t;
  osc_sync_st_t s_r;
  osc_sync_st_t s_nxt;

  // The first stage feeds only the second stage.
  always_comb begin
    s_nxt.meta = i_async;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_sync = s_r.sync;
endmodule
`default_nettype wire

// ### rtl/osc_irq.sv
// Sticky event flags, read-to-clear, mask and the level interrupt.
`timescale 1ns/1ps
`default_nettype none
module osc_irq import osc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire osc_irq_req_t i_req,
  output osc_irq_rsp_t o_rsp,
  output logic o_irq
);
  typedef struct packed {
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
  } osc_irq_st_t;
  osc_irq_st_t s_r;
  osc_irq_st_t s_nxt;

  // Only bits that the read actually returned are cleared, and a new
  // event in the clearing cycle still lands.
  always_comb begin
    s_nxt = s_r;
    s_nxt.status = (s_r.status & ~i_req.read_clr) | i_req.event_set;
    if (i_req.mask_we) begin
      s_nxt.mask = i_req.mask_wd;
    end
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rsp.status = s_r.status;
  assign o_rsp.mask = s_r.mask;
  assign o_irq = s_r.irq;

  irq_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (|(i_req.event_set & s_r.mask)) && !i_req.mask_we |=> o_irq)
    else $error("unmasked event did not raise the interrupt");
  set_wins_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_req.event_set[0] |=> s_r.status[0])
    else $error("event lost against a clear");
endmodule
`default_nettype wire

// ### rtl/osc_ctrl.sv
// Oscillator switch control, ready flags, manual enables and frequency.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "osc_defs.svh"
module osc_ctrl import osc_pkg::*; (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [5:0] I_OSC_READY,
  input wire logic I_PLL_LOCK,
  input wire logic [5:0] I_MODULE_REQ,
  input wire logic I_SWITCH_ALLOW_FUSE,
  input wire logic [2:0] I_RESET_SOURCE_FUSE,
  input wire logic [2:0] I_EXTERNAL_MODE_FUSE,
  output logic [5:0] O_OSC_ENABLE,
  output logic O_PLL_ENABLE,
  output logic [2:0] O_INT_OSC_FREQ_CODE,
  output logic O_SECONDARY_OSC_POWER_SELECT,
  output logic [2:0] O_EXTERNAL_MODE,
  output logic [2:0] O_CURRENT_SOURCE,
  output logic [3:0] O_CURRENT_DIVIDER,
  output logic O_IRQ
);
  typedef struct packed {
    osc_sw_state_t sw_state;
    logic [1:0] init_cnt;
    logic [2:0] req_src;
    logic [3:0] req_div;
    logic [2:0] cur_src;
    logic [3:0] cur_div;
    logic hold;
    logic spwr;
    logic [5:0] force_on;
    logic [2:0] frq;
    logic allow;
    logic [2:0] ext_mode;
    logic [5:0] osc_en;
    logic pll_en;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } osc_ctrl_st_t;

  osc_ctrl_st_t s;
  osc_ctrl_st_t n;
  osc_pins_t pins;
  osc_irq_req_t irq_req;
  osc_irq_rsp_t irq_rsp;
  logic in_prog;
  logic new_rdy;
  logic pll_ok;
  logic pll_in_ext;
  logic setup;
  logic done;
  logic [5:0] flags;
  logic [7:0] rd_byte;

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `OSC_OFF_REQ, `OSC_OFF_CUR, `OSC_OFF_CTRL, `OSC_OFF_RDY,
      `OSC_OFF_EN, `OSC_OFF_FRQ, `OSC_OFF_IST, `OSC_OFF_IMSK: begin
        is_mapped = 1'b1;
      end
      default: begin
        is_mapped = 1'b0;
      end
    endcase
  endfunction

  function automatic logic is_pll(input logic [2:0] src);
    is_pll = (src == `OSC_SRC_EXTPLL) || (src == `OSC_SRC_HFPLL);
  endfunction

  function automatic logic is_rsvd(input logic [2:0] src);
    is_rsvd = (src == `OSC_SRC_RSV0) || (src == `OSC_SRC_RSV1);
  endfunction

  // Oscillators that a source code keeps running; reserved codes act as
  // the high internal oscillator.
  function automatic logic [5:0] src_needs(input logic [2:0] src);
    src_needs = '0;
    case (src)
      `OSC_SRC_EXT, `OSC_SRC_EXTPLL: begin
        src_needs[`OSC_IDX_EXT] = 1'b1;
      end
      `OSC_SRC_LF: begin
        src_needs[`OSC_IDX_LF] = 1'b1;
      end
      `OSC_SRC_SOS: begin
        src_needs[`OSC_IDX_SOS] = 1'b1;
      end
      default: begin
        src_needs[`OSC_IDX_HF] = 1'b1;
      end
    endcase
  endfunction

  function automatic logic src_ready(input logic [2:0] src,
                                     input logic [5:0] rdy,
                                     input logic pll_rdy);
    case (src)
      `OSC_SRC_EXT: begin
        src_ready = rdy[`OSC_IDX_EXT];
      end
      `OSC_SRC_LF: begin
        src_ready = rdy[`OSC_IDX_LF];
      end
      `OSC_SRC_SOS: begin
        src_ready = rdy[`OSC_IDX_SOS];
      end
      `OSC_SRC_EXTPLL, `OSC_SRC_HFPLL: begin
        src_ready = pll_rdy;
      end
      default: begin
        src_ready = rdy[`OSC_IDX_HF];
      end
    endcase
  endfunction

  // Pins and fuses come from outside the clock domain.
  osc_sync #(.W($bits(osc_pins_t))) u_sync (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_async({I_OSC_READY, I_PLL_LOCK, I_MODULE_REQ, I_SWITCH_ALLOW_FUSE,
              I_RESET_SOURCE_FUSE, I_EXTERNAL_MODE_FUSE}),
    .o_sync(pins)
  );

  osc_irq u_irq (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_req(irq_req),
    .o_rsp(irq_rsp),
    .o_irq(O_IRQ)
  );

  always_comb begin
    pll_in_ext = is_pll(s.req_src) ? (s.req_src == `OSC_SRC_EXTPLL)
                                   : (s.cur_src == `OSC_SRC_EXTPLL);
    pll_ok = s.pll_en && pins.pll_lock &&
             (pll_in_ext ? pins.osc_rdy[`OSC_IDX_EXT]
                         : pins.osc_rdy[`OSC_IDX_HF]);
    flags = pins.osc_rdy & s.osc_en;
    in_prog = (s.req_src != s.cur_src) || (s.req_div != s.cur_div);
    new_rdy = in_prog && src_ready(s.req_src, pins.osc_rdy, pll_ok);
    setup = I_PSEL && !s.pready && (s.sw_state != ST_INIT);
    done = I_PSEL && I_PENABLE && s.pready;
    rd_byte = '0;
    case (I_PADDR)
      `OSC_OFF_REQ: begin
        rd_byte[`OSC_SRC_MSB:`OSC_SRC_LSB] = s.req_src;
        rd_byte[`OSC_DIV_MSB:`OSC_DIV_LSB] = s.req_div;
      end
      `OSC_OFF_CUR: begin
        rd_byte[`OSC_SRC_MSB:`OSC_SRC_LSB] = s.cur_src;
        rd_byte[`OSC_DIV_MSB:`OSC_DIV_LSB] = s.cur_div;
      end
      `OSC_OFF_CTRL: begin
        rd_byte[`OSC_BIT_HOLD] = s.hold;
        rd_byte[`OSC_BIT_SPWR] = s.spwr;
        rd_byte[`OSC_BIT_CMPL] = !in_prog;
        rd_byte[`OSC_BIT_NRDY] = new_rdy;
      end
      `OSC_OFF_RDY: begin
        rd_byte[`OSC_FLG_MSB:`OSC_FLG_LSB] = flags;
        rd_byte[`OSC_BIT_MULTIPLIER_READY] = pll_ok;
      end
      `OSC_OFF_EN: begin
        rd_byte[`OSC_FLG_MSB:`OSC_FLG_LSB] = s.force_on;
      end
      `OSC_OFF_FRQ: begin
        rd_byte[`OSC_FRQ_MSB:`OSC_FRQ_LSB] = s.frq;
      end
      `OSC_OFF_IST: begin
        rd_byte[1:0] = irq_rsp.status;
      end
      `OSC_OFF_IMSK: begin
        rd_byte[1:0] = irq_rsp.mask;
      end
      default: begin
        rd_byte = '0;
      end
    endcase
  end

  always_comb begin
    n = s;
    irq_req = '0;
    n.pready = setup;
    if (setup) begin
      n.prdata = {24'h000000, rd_byte};
      n.pslverr = !is_mapped(I_PADDR);
    end
    if (done && !I_PWRITE && (I_PADDR == `OSC_OFF_IST)) begin
      irq_req.read_clr = s.prdata[1:0];
    end
    if (done && I_PWRITE) begin
      case (I_PADDR)
        `OSC_OFF_REQ: begin
          if (s.allow &&
              !is_rsvd(I_PWDATA[`OSC_SRC_MSB:`OSC_SRC_LSB])) begin
            n.req_src = I_PWDATA[`OSC_SRC_MSB:`OSC_SRC_LSB];
            n.req_div = I_PWDATA[`OSC_DIV_MSB:`OSC_DIV_LSB];
          end
        end
        `OSC_OFF_CTRL: begin
          n.hold = I_PWDATA[`OSC_BIT_HOLD];
          n.spwr = I_PWDATA[`OSC_BIT_SPWR];
        end
        `OSC_OFF_EN: begin
          n.force_on = I_PWDATA[`OSC_FLG_MSB:`OSC_FLG_LSB];
        end
        `OSC_OFF_FRQ: begin
          // A reserved frequency code would leave the oscillator
          // undefined, so it is dropped.
          if (I_PWDATA[`OSC_FRQ_MSB:`OSC_FRQ_LSB] != `OSC_FRQ_RSVD) begin
            n.frq = I_PWDATA[`OSC_FRQ_MSB:`OSC_FRQ_LSB];
          end
        end
        `OSC_OFF_IMSK: begin
          irq_req.mask_we = 1'b1;
          irq_req.mask_wd = I_PWDATA[1:0];
        end
        default: begin
          n.pslverr = s.pslverr;
        end
      endcase
    end
    case (s.sw_state)
      ST_INIT: begin
        // Fuses are taken only once the synchroniser has settled.
        n.init_cnt = s.init_cnt + 2'h1;
        if (s.init_cnt == `OSC_SYNC_WAIT) begin
          n.sw_state = ST_IDLE;
          n.allow = pins.allow;
          n.ext_mode = pins.ext_mode;
          n.req_src = pins.rst_src;
          n.cur_src = pins.rst_src;
          n.req_div = (pins.rst_src == `OSC_SRC_HF) ? `OSC_DIV_RST_HF
                                                    : `OSC_DIV_RST;
          n.cur_div = n.req_div;
          n.frq = (pins.rst_src == `OSC_SRC_RSV0) ? `OSC_FRQ_32M
                                                  : `OSC_FRQ_4M;
        end
      end
      ST_IDLE: begin
        if (in_prog) begin
          n.sw_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!in_prog) begin
          n.sw_state = ST_IDLE;
        end else if (new_rdy && s.hold) begin
          n.sw_state = ST_HOLD;
          irq_req.event_set[`OSC_IRQ_HELD] = 1'b1;
        end else if (new_rdy) begin
          n.cur_src = s.req_src;
          n.cur_div = s.req_div;
          n.sw_state = ST_IDLE;
          irq_req.event_set[`OSC_IRQ_DONE] = 1'b1;
        end
      end
      ST_HOLD: begin
        if (!in_prog) begin
          n.sw_state = ST_IDLE;
        end else if (!new_rdy) begin
          n.sw_state = ST_WAIT;
        end else if (!s.hold) begin
          n.cur_src = s.req_src;
          n.cur_div = s.req_div;
          n.sw_state = ST_IDLE;
          irq_req.event_set[`OSC_IRQ_DONE] = 1'b1;
        end
      end
      default: begin
        n.sw_state = ST_INIT;
      end
    endcase
    n.osc_en = s.force_on | pins.mod_req |
               src_needs(s.req_src) | src_needs(s.cur_src);
    n.pll_en = is_pll(s.req_src) || is_pll(s.cur_src);
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign O_PRDATA = s.prdata;
  assign O_PREADY = s.pready;
  assign O_PSLVERR = s.pslverr;
  assign O_OSC_ENABLE = s.osc_en;
  assign O_PLL_ENABLE = s.pll_en;
  assign O_INT_OSC_FREQ_CODE = s.frq;
  assign O_SECONDARY_OSC_POWER_SELECT = s.spwr;
  assign O_EXTERNAL_MODE = s.ext_mode;
  assign O_CURRENT_SOURCE = s.cur_src;
  assign O_CURRENT_DIVIDER = s.cur_div;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  sequence s_ready_wait;
    (s.sw_state == ST_WAIT) && new_rdy;
  endsequence
  sequence s_held;
    (s.sw_state == ST_HOLD) && s.hold;
  endsequence
  sequence s_init_end;
    (s.sw_state == ST_INIT) && (s.init_cnt == `OSC_SYNC_WAIT);
  endsequence

  hold_enter_a: assert property (
    s_ready_wait ##0 s.hold |=> (s.sw_state == ST_HOLD) &&
      $stable(O_CURRENT_SOURCE) ##1 irq_rsp.status[`OSC_IRQ_HELD])
    else $error("held switch did not pause or flag");
  auto_switch_a: assert property (
    s_ready_wait ##0 !s.hold |=>
      (O_CURRENT_SOURCE == $past(s.req_src)) &&
      (O_CURRENT_DIVIDER == $past(s.req_div)))
    else $error("switch did not complete on ready");
  hold_keeps_a: assert property (
    s_held |=> $stable(O_CURRENT_SOURCE) && $stable(O_CURRENT_DIVIDER))
    else $error("clock changed while held");
  release_go_a: assert property (
    (s.sw_state == ST_HOLD) && !s.hold && new_rdy |=>
      O_CURRENT_SOURCE == $past(s.req_src))
    else $error("released switch did not complete");
  power_sel_a: assert property (
    done && I_PWRITE && (I_PADDR == `OSC_OFF_CTRL) |=>
      O_SECONDARY_OSC_POWER_SELECT == $past(I_PWDATA[`OSC_BIT_SPWR]))
    else $error("power select not applied");
  flag_read_a: assert property (
    setup && (I_PADDR == `OSC_OFF_CTRL) |=>
      (O_PRDATA[`OSC_BIT_CMPL] == $past(!in_prog)) &&
      (O_PRDATA[`OSC_BIT_NRDY] == $past(new_rdy)))
    else $error("switch flags read wrong");
  pll_flag_a: assert property (
    pll_ok |-> O_PLL_ENABLE && pins.pll_lock)
    else $error("multiplier ready without enable or lock");
  force_on_a: assert property (
    ##1 (|s.force_on) |=> (O_OSC_ENABLE & $past(s.force_on)) ==
      $past(s.force_on))
    else $error("forced oscillator not enabled");
  rsvd_src_a: assert property (
    done && I_PWRITE && (I_PADDR == `OSC_OFF_REQ) &&
      is_rsvd(I_PWDATA[`OSC_SRC_MSB:`OSC_SRC_LSB]) |=>
      $stable(s.req_src) && $stable(s.req_div))
    else $error("reserved source write took effect");
  fuse_lock_a: assert property (
    (s.sw_state != ST_INIT) && !s.allow |=>
      $stable(s.req_src) && $stable(s.req_div))
    else $error("locked request register changed");
  freq_reset_a: assert property (
    s_init_end |=> s.frq == (($past(pins.rst_src) == `OSC_SRC_RSV0) ?
      `OSC_FRQ_32M : `OSC_FRQ_4M))
    else $error("frequency reset value wrong");
  freq_rsvd_a: assert property (
    done && I_PWRITE && (I_PADDR == `OSC_OFF_FRQ) &&
      (I_PWDATA[`OSC_FRQ_MSB:`OSC_FRQ_LSB] == `OSC_FRQ_RSVD) |=>
      $stable(s.frq))
    else $error("reserved frequency code stored");
  zero_bits_a: assert property (
    setup && (I_PADDR == `OSC_OFF_EN) |=>
      (O_PRDATA[1:0] == 2'h0) && (O_PRDATA[31:8] == 24'h000000))
    else $error("unused bits read nonzero");
endmodule
`default_nettype wire

// ### tb/osc_ctrl_test.sv
// Self-checking bench for the oscillator control block.
`timescale 1ns/1ps
`default_nettype none
`include "osc_defs.svh"
module osc_ctrl_test import osc_pkg::*; ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic last_err;
  logic [5:0] osc_rdy = 6'h3b;
  logic [5:0] mod_req = 6'h00;
  logic pll_lock = 1'b0;
  logic allow = 1'b1;
  logic [2:0] rst_src = 3'h6;
  logic [2:0] ext_mode = 3'h5;
  logic [5:0] osc_en;
  logic pll_en;
  logic [2:0] frq;
  logic spwr;
  logic [2:0] ext_out;
  logic [2:0] cur_src;
  logic [3:0] cur_div;
  logic irq;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  osc_ctrl u_osc_ctrl (
    .I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_OSC_READY(osc_rdy), .I_PLL_LOCK(pll_lock), .I_MODULE_REQ(mod_req),
    .I_SWITCH_ALLOW_FUSE(allow), .I_RESET_SOURCE_FUSE(rst_src),
    .I_EXTERNAL_MODE_FUSE(ext_mode), .O_OSC_ENABLE(osc_en),
    .O_PLL_ENABLE(pll_en), .O_INT_OSC_FREQ_CODE(frq),
    .O_SECONDARY_OSC_POWER_SELECT(spwr), .O_EXTERNAL_MODE(ext_out),
    .O_CURRENT_SOURCE(cur_src), .O_CURRENT_DIVIDER(cur_div), .O_IRQ(irq)
  );

  always #50 clk = ~clk;

  task automatic wrap_up();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A run that never reaches wrap_up is ended after 20000 cycles and counted as a failure.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) chk("apb answer", 32'h1, 32'h0);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask

  task automatic rdc(input string w, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] x;
    apb(1'b0, a, 32'h0, x);
    chk(w, e, x);
  endtask

  task automatic wait_src(input logic [2:0] s);
    int n = 0;
    while (cur_src !== s && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("current source", {29'h0, s}, {29'h0, cur_src});
  endtask

  task automatic t_reset();
    rdc("freq reset", `OSC_OFF_FRQ, 32'h02);
    rdc("request reset", `OSC_OFF_REQ, 32'h62);
    rdc("current reset", `OSC_OFF_CUR, 32'h62);
    rdc("switch flags idle", `OSC_OFF_CTRL, 32'h10);
    chk("external mode", 32'h5, {29'h0, ext_out});
  endtask

  task automatic t_freq();
    for (int c = 0; c < 7; c++) begin
      wr(`OSC_OFF_FRQ, 32'hf8 | 32'(c));
      rdc("freq code", `OSC_OFF_FRQ, 32'(c));
      chk("freq out", 32'(c), {29'h0, frq});
    end
    wr(`OSC_OFF_FRQ, 32'h07);
    rdc("freq reserved", `OSC_OFF_FRQ, 32'h06);
  endtask

  task automatic t_force();
    logic [5:0] b;
    for (int i = 0; i < 6; i++) begin
      b = 6'h01 << i;
      wr(`OSC_OFF_EN, {24'h0, b, 2'b00});
      ticks(2);
      chk("enable out", {26'h0, b | 6'h10}, {26'h0, osc_en});
    end
    wr(`OSC_OFF_EN, 32'hff);
    rdc("force unused bits", `OSC_OFF_EN, 32'hfc);
    wr(`OSC_OFF_EN, 32'h00);
    mod_req <= 6'h20;
    ticks(5);
    chk("module request", 32'h30, {26'h0, osc_en});
    rdc("ready flags", `OSC_OFF_RDY, 32'hc0);
    mod_req <= 6'h00;
    ticks(5);
    rdc("ready flags idle", `OSC_OFF_RDY, 32'h40);
  endtask

  task automatic t_power();
    wr(`OSC_OFF_CTRL, 32'h40);
    ticks(1);
    chk("power high", 32'h1, {31'h0, spwr});
    rdc("power bit", `OSC_OFF_CTRL, 32'h50);
    wr(`OSC_OFF_CTRL, 32'h00);
    ticks(1);
    chk("power low", 32'h0, {31'h0, spwr});
  endtask

  task automatic t_switch();
    wr(`OSC_OFF_IMSK, 32'h03);
    wr(`OSC_OFF_REQ, 32'h51);
    ticks(3);
    rdc("switch pending", `OSC_OFF_CTRL, 32'h00);
    chk("source kept", 32'h6, {29'h0, cur_src});
    osc_rdy <= 6'h3f;
    wait_src(3'h5);
    chk("divider", 32'h1, {28'h0, cur_div});
    ticks(3);
    chk("irq raised", 32'h1, {31'h0, irq});
    rdc("status done", `OSC_OFF_IST, 32'h02);
    ticks(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdc("switch done", `OSC_OFF_CTRL, 32'h10);
  endtask

  task automatic t_hold();
    wr(`OSC_OFF_CTRL, 32'h80);
    wr(`OSC_OFF_REQ, 32'h62);
    ticks(10);
    chk("held source", 32'h5, {29'h0, cur_src});
    rdc("held flags", `OSC_OFF_CTRL, 32'h88);
    chk("held irq", 32'h1, {31'h0, irq});
    rdc("status held", `OSC_OFF_IST, 32'h01);
    wr(`OSC_OFF_IMSK, 32'h01);
    wr(`OSC_OFF_CTRL, 32'h00);
    wait_src(3'h6);
    chk("divider back", 32'h2, {28'h0, cur_div});
    ticks(3);
    chk("masked irq", 32'h0, {31'h0, irq});
    rdc("status masked", `OSC_OFF_IST, 32'h02);
  endtask

  task automatic t_refused();
    logic [31:0] x;
    wr(`OSC_OFF_REQ, 32'h31);
    rdc("reserved 011", `OSC_OFF_REQ, 32'h62);
    wr(`OSC_OFF_REQ, 32'h05);
    rdc("reserved 000", `OSC_OFF_REQ, 32'h62);
    wr(`OSC_OFF_CUR, 32'h00);
    rdc("current read-only", `OSC_OFF_CUR, 32'h62);
    apb(1'b0, 8'h20, 32'h0, x);
    chk("unmapped data", 32'h0, x);
    chk("unmapped error", 32'h1, {31'h0, last_err});
  endtask

  task automatic t_pll();
    wr(`OSC_OFF_REQ, 32'h12);
    ticks(4);
    chk("multiplier enable", 32'h1, {31'h0, pll_en});
    rdc("multiplier unlocked", `OSC_OFF_RDY, 32'h40);
    chk("no switch unlocked", 32'h6, {29'h0, cur_src});
    pll_lock <= 1'b1;
    wait_src(3'h1);
    rdc("multiplier ready", `OSC_OFF_RDY, 32'h41);
    pll_lock <= 1'b0;
    ticks(4);
    rdc("multiplier lost", `OSC_OFF_RDY, 32'h40);
  endtask

  task automatic t_locked();
    rst_n <= 1'b0;
    allow <= 1'b0;
    rst_src <= 3'h0;
    ticks(2);
    rst_n <= 1'b1;
    rdc("freq reset 32", `OSC_OFF_FRQ, 32'h06);
    rdc("request fuse", `OSC_OFF_REQ, 32'h00);
    wr(`OSC_OFF_REQ, 32'h51);
    rdc("request locked", `OSC_OFF_REQ, 32'h00);
  endtask

  initial begin
    ticks(2);
    rst_n <= 1'b1;
    t_reset();
    t_freq();
    t_force();
    t_power();
    t_switch();
    t_hold();
    t_refused();
    t_pll();
    t_locked();
    wrap_up();
  end
endmodule
`default_nettype wire
